// ---- core/vatu_translation_unit.sv ----
`timescale 1ns/1ps
`include "vatu_consts.svh"

module vatu_translation_unit
  import vatu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        reqValid,
  input  wire logic [31:0] reqAddr,
  input  wire logic [1:0]  reqKind,
  input  wire logic        reqUserLow,
  input  wire logic        reqContextPtr,
  input  wire logic        segCacheAttr,
  output logic             rspValid,
  output logic      [31:0] rspAddr,
  output logic             rspCacheable,
  output logic             rspRangeCheck,
  output logic             rspFillTrap,
  output logic             rspProtTrap,
  output logic             rspTrapId
);

  vatu_state_t st_q;
  vatu_state_t st_d;

  // Page number of va for a buffer with size code sz
  function automatic logic [`VATU_PN_W-1:0] pageNum(input logic [31:0] va,
                                                    input logic [1:0]  sz);
    logic [31:0] sh;
    sh = va >> (`VATU_SHIFT_BASE + 2 * sz);
    pageNum = sh[`VATU_PN_W-1:0];
  endfunction : pageNum

  // Physical page number joined to the untouched offset
  function automatic logic [31:0] joinPhys(input logic [31:0]            va,
                                           input logic [`VATU_PN_W-1:0] physical_page_number,
                                           input logic [1:0]            sz);
    logic [31:0] mask;
    mask = (32'h0000_0400 << (2 * sz)) - 32'h0000_0001;
    joinPhys = ({10'h000, physical_page_number} << (`VATU_SHIFT_BASE + 2 * sz)) | (va & mask);
  endfunction : joinPhys

  function automatic logic entryHit(input vatu_entry_t e,
                                    input logic [31:0] va,
                                    input logic [1:0]  sz,
                                    input logic [4:0]  asid);
    entryHit = e.valid && (e.virtual_page_number == pageNum(va, sz))
               && (e.global || (e.asid == asid));
  endfunction : entryHit

  function automatic logic [31:0] byteMerge(input logic [31:0] old,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  be);
    for (int b = 0; b < 4; b++) begin
      old[8*b +: 8] = be[b] ? wdata[8*b +: 8] : old[8*b +: 8];
    end
    byteMerge = old;
  endfunction : byteMerge

  function automatic vatu_entry_t stageEntry(input logic [31:0] vw,
                                             input logic [31:0] pw);
    vatu_entry_t e;
    e.virtual_page_number         = vw[`VATU_PN_W-1:0];
    e.asid        = vw[`VATU_VPN_ASID_LSB +: 5];
    e.physical_page_number         = pw[`VATU_PN_W-1:0];
    e.valid       = pw[`VATU_PPN_FLAG_LSB];
    e.global      = pw[`VATU_PPN_FLAG_LSB + 1];
    e.cacheable   = pw[`VATU_PPN_FLAG_LSB + 2];
    e.readPermit  = pw[`VATU_PPN_FLAG_LSB + 3];
    e.writePermit = pw[`VATU_PPN_FLAG_LSB + 4];
    e.execPermit  = pw[`VATU_PPN_FLAG_LSB + 5];
    stageEntry = e;
  endfunction : stageEntry

  logic [31:0] cfgWord;
  logic [31:0] curWord;
  logic [31:0] newWord;
  logic        busReq;
  logic        busTake;
  logic        hitA;
  logic        hitB;
  vatu_entry_t selEnt;
  logic [1:0]  selSize;
  logic [1:0]  minSize;
  logic [3:0]  segment;
  logic        upperHalf;
  logic        pageMode;
  logic        userRefused;
  logic        permOk;
  logic [31:0] faultShift;

  always_comb begin
    st_d = st_q;

    // Register view
    cfgWord = 32'h0000_0000;
    cfgWord[`VATU_CFG_VIRT_BIT]          = st_q.virtualModeSelect;
    cfgWord[`VATU_CFG_SZA_LSB +: 2]      = st_q.firstBufferPageSize;
    cfgWord[`VATU_CFG_SZB_LSB +: 2]      = st_q.secondBufferPageSize;
    cfgWord[`VATU_CFG_CNT_LSB +: 7]      = `VATU_ENTRY_MAX;
    cfgWord[`VATU_CFG_ABSENT_BIT]        = 1'b0;
    unique case (avs_address)
      `VATU_OFF_CONFIG:    curWord = cfgWord;
      `VATU_OFF_ASID:      curWord = {27'h0000000, st_q.addressSpaceId};
      `VATU_OFF_INDEX:     curWord = {24'h000000, st_q.entryIndex};
      `VATU_OFF_STAGE_VPN: curWord = st_q.stageVpn;
      `VATU_OFF_STAGE_PPN: curWord = st_q.stagePpn;
      `VATU_OFF_FAULT:     curWord = st_q.faultAddress;
      `VATU_OFF_TRAP:      curWord = {30'h00000000, st_q.trapSeen, st_q.lastTrapId};
      default:             curWord = 32'h0000_0000;
    endcase
    newWord = byteMerge(curWord, avs_writedata, avs_byteenable);

    // Two-cycle bus answer: wait high first cycle, low the second
    busReq  = avs_read || avs_write;
    busTake = busReq && !st_q.waitReq;
    st_d.waitReq = !(busReq && st_q.waitReq);
    if (busReq && st_q.waitReq) begin
      st_d.readData = avs_read ? curWord : 32'h0000_0000;
    end

    if (busTake && avs_write) begin
      unique case (avs_address)
        `VATU_OFF_CONFIG: begin
          st_d.virtualModeSelect    = newWord[`VATU_CFG_VIRT_BIT];
          st_d.firstBufferPageSize  = newWord[`VATU_CFG_SZA_LSB +: 2];
          st_d.secondBufferPageSize = newWord[`VATU_CFG_SZB_LSB +: 2];
        end
        `VATU_OFF_ASID:      st_d.addressSpaceId = newWord[4:0];
        `VATU_OFF_INDEX:     st_d.entryIndex     = newWord[7:0];
        `VATU_OFF_STAGE_VPN: st_d.stageVpn       = newWord;
        `VATU_OFF_STAGE_PPN: st_d.stagePpn       = newWord;
        `VATU_OFF_COMMIT: begin
          // Out-of-range indices are dropped
          if (st_q.entryIndex <= {1'b0, `VATU_ENTRY_MAX}) begin
            st_d.firstBuf[st_q.entryIndex[2:0]] = stageEntry(st_q.stageVpn, st_q.stagePpn);
          end else if (st_q.entryIndex >= `VATU_SECOND_BASE &&
                       st_q.entryIndex <= (`VATU_SECOND_BASE | {1'b0, `VATU_ENTRY_MAX})) begin
            st_d.secondBuf[st_q.entryIndex[2:0]] = stageEntry(st_q.stageVpn, st_q.stagePpn);
          end
        end
        default: begin
        end
      endcase
    end

    // Lookup in both buffers
    hitA = 1'b0;
    hitB = 1'b0;
    selEnt  = st_q.firstBuf[0];
    selSize = st_q.firstBufferPageSize;
    for (int i = 0; i < `VATU_ENTRIES; i++) begin
      if (entryHit(st_q.firstBuf[i], reqAddr, st_q.firstBufferPageSize,
                   st_q.addressSpaceId)) begin
        hitA   = 1'b1;
        selEnt = st_q.firstBuf[i];
      end
    end
    for (int i = 0; i < `VATU_ENTRIES; i++) begin
      if (entryHit(st_q.secondBuf[i], reqAddr, st_q.secondBufferPageSize,
                   st_q.addressSpaceId)) begin
        hitB = 1'b1;
        if (!hitA) begin
          selEnt  = st_q.secondBuf[i];
          selSize = st_q.secondBufferPageSize;
        end
      end
    end

    segment   = reqAddr[`VATU_SEG_LSB +: 4];
    upperHalf = reqAddr[31];
    pageMode  = st_q.virtualModeSelect && !upperHalf && !reqContextPtr;

    if (st_q.virtualModeSelect) begin
      userRefused = reqUserLow && upperHalf;
    end else begin
      userRefused = reqUserLow && (segment >= `VATU_SEG_USER_MIN);
    end

    unique case (reqKind)
      VATU_ACC_FETCH: permOk = selEnt.execPermit;
      VATU_ACC_WRITE: permOk = selEnt.writePermit;
      default:        permOk = selEnt.readPermit;
    endcase

    minSize = (st_q.firstBufferPageSize < st_q.secondBufferPageSize) ?
              st_q.firstBufferPageSize : st_q.secondBufferPageSize;
    faultShift = reqAddr >> (`VATU_SHIFT_BASE + 2 * minSize);

    // Response, all fields in one registered cycle
    st_d.rspValid    = reqValid;
    st_d.rspFillTrap = 1'b0;
    st_d.rspProtTrap = 1'b0;
    st_d.rspTrapId   = `VATU_TIN_FILL;
    if (reqValid) begin
      if (pageMode) begin
        st_d.rspAddr       = joinPhys(reqAddr, selEnt.physical_page_number, selSize);
        st_d.rspCacheable  = selEnt.cacheable && segCacheAttr;
        st_d.rspRangeCheck = 1'b0;
        if (!(hitA ^ hitB)) begin
          st_d.rspFillTrap = 1'b1;
          st_d.rspTrapId   = `VATU_TIN_FILL;
        end else if (!permOk || userRefused) begin
          st_d.rspProtTrap = 1'b1;
          st_d.rspTrapId   = `VATU_TIN_PROT;
        end
      end else begin
        st_d.rspAddr       = reqAddr;
        st_d.rspCacheable  = segCacheAttr;
        st_d.rspRangeCheck = 1'b1;
        if (userRefused) begin
          st_d.rspProtTrap = 1'b1;
          st_d.rspTrapId   = `VATU_TIN_PROT;
        end
      end
      if (st_d.rspFillTrap || st_d.rspProtTrap) begin
        st_d.faultAddress = faultShift;
        st_d.lastTrapId   = st_d.rspTrapId;
        st_d.trapSeen     = 1'b1;
      end
    end

    // Reading the trap register clears the seen flag unless a new trap lands
    if (busTake && avs_read && avs_address == `VATU_OFF_TRAP &&
        !(st_d.rspFillTrap || st_d.rspProtTrap)) begin
      st_d.trapSeen = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.waitReq              <= 1'b1;
      st_q.firstBufferPageSize  <= `VATU_RST_SIZE;
      st_q.secondBufferPageSize <= `VATU_RST_SIZE;
      st_q.addressSpaceId       <= `VATU_RST_ASID;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_readdata    = st_q.readData;
  assign avs_waitrequest = st_q.waitReq;
  assign rspValid        = st_q.rspValid;
  assign rspAddr         = st_q.rspAddr;
  assign rspCacheable    = st_q.rspCacheable;
  assign rspRangeCheck   = st_q.rspRangeCheck;
  assign rspFillTrap     = st_q.rspFillTrap;
  assign rspProtTrap     = st_q.rspProtTrap;
  assign rspTrapId       = st_q.rspTrapId;

endmodule : vatu_translation_unit

// ---- core/vatu_consts.svh ----
`ifndef VATU_CONSTS_SVH
`define VATU_CONSTS_SVH

// Register byte offsets
`define VATU_OFF_CONFIG     8'h00
`define VATU_OFF_ASID       8'h04
`define VATU_OFF_INDEX      8'h08
`define VATU_OFF_STAGE_VPN  8'h0C
`define VATU_OFF_STAGE_PPN  8'h10
`define VATU_OFF_COMMIT     8'h14
`define VATU_OFF_FAULT      8'h18
`define VATU_OFF_TRAP       8'h1C

// Configuration register fields
`define VATU_CFG_VIRT_BIT   0
`define VATU_CFG_SZA_LSB    1
`define VATU_CFG_SZB_LSB    3
`define VATU_CFG_CNT_LSB    5
`define VATU_CFG_ABSENT_BIT 15

// Staged entry fields
`define VATU_VPN_ASID_LSB   24
`define VATU_PPN_FLAG_LSB   26

// Buffer geometry
`define VATU_ENTRIES        8
`define VATU_ENTRY_MAX      7'h07
`define VATU_SECOND_BASE    8'h80
`define VATU_PN_W           22
`define VATU_SHIFT_BASE     10

// Address fields
`define VATU_SEG_LSB        28
`define VATU_SEG_USER_MIN   4'hE

// Trap identification numbers
`define VATU_TIN_FILL       1'b0
`define VATU_TIN_PROT       1'b1

// Reset values
`define VATU_RST_SIZE       2'h0
`define VATU_RST_ASID       5'h00

`endif

// ---- core/vatu_pkg.sv ----
`include "vatu_consts.svh"

package vatu_pkg;

  typedef enum logic [1:0] {
    VATU_ACC_READ,
    VATU_ACC_WRITE,
    VATU_ACC_FETCH
  } vatu_acc_t;

  typedef struct packed {
    logic [`VATU_PN_W-1:0] virtual_page_number;
    logic [`VATU_PN_W-1:0] physical_page_number;
    logic [4:0]            asid;
    logic                  execPermit;
    logic                  writePermit;
    logic                  readPermit;
    logic                  cacheable;
    logic                  global;
    logic                  valid;
  } vatu_entry_t;

  typedef struct packed {
    logic                                 waitReq;
    logic [31:0]                          readData;
    logic                                 virtualModeSelect;
    logic [1:0]                           firstBufferPageSize;
    logic [1:0]                           secondBufferPageSize;
    logic [4:0]                           addressSpaceId;
    logic [7:0]                           entryIndex;
    logic [31:0]                          stageVpn;
    logic [31:0]                          stagePpn;
    vatu_entry_t [`VATU_ENTRIES-1:0]      firstBuf;
    vatu_entry_t [`VATU_ENTRIES-1:0]      secondBuf;
    logic [31:0]                          faultAddress;
    logic                                 lastTrapId;
    logic                                 trapSeen;
    logic                                 rspValid;
    logic [31:0]                          rspAddr;
    logic                                 rspCacheable;
    logic                                 rspRangeCheck;
    logic                                 rspFillTrap;
    logic                                 rspProtTrap;
    logic                                 rspTrapId;
  } vatu_state_t;

endpackage : vatu_pkg

// ---- bench/vatu_properties.sv ----
`timescale 1ns/1ps
module vatu_checker (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        reqValid,
  input wire logic [31:0] reqAddr,
  input wire logic        reqUserLow,
  input wire logic        reqContextPtr,
  input wire logic        segCacheAttr,
  input wire logic        rspValid,
  input wire logic [31:0] rspAddr,
  input wire logic        rspCacheable,
  input wire logic        rspRangeCheck,
  input wire logic        rspFillTrap,
  input wire logic        rspProtTrap,
  input wire logic        rspTrapId
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_lat;
    reqValid |=> rspValid;
  endproperty
  property p_idle;
    !reqValid |=> !rspValid && !rspFillTrap && !rspProtTrap;
  endproperty
  property p_upper;
    reqValid && reqAddr[31] && !reqUserLow |=>
      rspRangeCheck && rspAddr == $past(reqAddr) && !rspFillTrap && !rspProtTrap;
  endproperty
  property p_ctx;
    reqValid && reqContextPtr && !reqUserLow |=>
      rspRangeCheck && rspAddr == $past(reqAddr) && !rspFillTrap;
  endproperty
  property p_dcache;
    rspValid && rspRangeCheck && !rspProtTrap |-> rspCacheable == $past(segCacheAttr);
  endproperty
  sequence s_page_ok;
    rspValid && !rspRangeCheck && !rspFillTrap && !rspProtTrap;
  endsequence
  property p_pcache;
    s_page_ok |-> !rspCacheable || $past(segCacheAttr);
  endproperty
  property p_offs;
    s_page_ok |-> rspAddr[9:0] == $past(reqAddr[9:0]);
  endproperty
  property p_seg;
    reqValid && reqUserLow && reqAddr[31:29] == 3'h7 |=>
      rspProtTrap && rspTrapId && !rspFillTrap;
  endproperty
  property p_tin;
    (rspFillTrap |-> !rspTrapId && !rspProtTrap) and (rspProtTrap |-> rspTrapId);
  endproperty

  a_lat: assert property (p_lat) else $error("no response after request");
  a_idle: assert property (p_idle) else $error("response without request");
  a_upper: assert property (p_upper) else $error("upper half not direct");
  a_ctx: assert property (p_ctx) else $error("context pointer not direct");
  a_dcache: assert property (p_dcache) else $error("direct cacheable wrong");
  a_pcache: assert property (p_pcache) else $error("page cacheable wrong");
  a_offs: assert property (p_offs) else $error("page offset changed");
  a_seg: assert property (p_seg) else $error("top segments not refused");
  a_tin: assert property (p_tin) else $error("trap number wrong");

  c_fill: cover property (rspFillTrap);
  c_prot: cover property (rspProtTrap);
  c_page: cover property (s_page_ok);
endmodule : vatu_checker

bind vatu_translation_unit vatu_checker i_vatu_checker (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reqValid(reqValid), .reqAddr(reqAddr),
  .reqUserLow(reqUserLow), .reqContextPtr(reqContextPtr), .segCacheAttr(segCacheAttr),
  .rspValid(rspValid), .rspAddr(rspAddr), .rspCacheable(rspCacheable),
  .rspRangeCheck(rspRangeCheck), .rspFillTrap(rspFillTrap), .rspProtTrap(rspProtTrap),
  .rspTrapId(rspTrapId));

// ---- bench/vatu_core_model.sv ----
`timescale 1ns/1ps
module vatu_core_model (
  input  wire logic        clk_sys,
  input  wire logic        cmdGo,
  input  wire logic [31:0] cmdAddr,
  input  wire logic [1:0]  cmdKind,
  input  wire logic [2:0]  cmdFlags,
  output logic             reqValid,
  output logic      [31:0] reqAddr,
  output logic      [1:0]  reqKind,
  output logic             reqUserLow,
  output logic             reqContextPtr,
  output logic             segCacheAttr
);
  initial begin
    {reqValid, reqAddr, reqKind, reqUserLow, reqContextPtr, segCacheAttr} = '0;
  end

  always @(posedge clk_sys) begin
    reqValid <= cmdGo;
    if (cmdGo) begin
      reqAddr <= cmdAddr;
      reqKind <= cmdKind;
      {reqUserLow, reqContextPtr, segCacheAttr} <= cmdFlags;
    end else begin
      // Idle qualifiers toggle so stale values never look valid
      reqAddr <= ~reqAddr;
      reqKind <= ~reqKind;
      {reqUserLow, reqContextPtr, segCacheAttr} <= ~{reqUserLow, reqContextPtr, segCacheAttr};
    end
  end
endmodule : vatu_core_model

// ---- bench/test_virtual_address_translation_unit.sv ----
`timescale 1ns/1ps
`include "vatu_consts.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failCount++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end

module test_virtual_address_translation_unit;
  logic        clk_sys       = 1'b0;
  logic        sys_rst       = 1'b1;
  logic [7:0]  avs_address   = 8'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        cmdGo         = 1'b0;
  logic [31:0] cmdAddr       = 32'h0;
  logic [1:0]  cmdKind       = 2'h0;
  logic [2:0]  cmdFlags      = 3'h0;
  logic [31:0] avs_readdata, reqAddr, rspAddr, rdData;
  logic [1:0]  reqKind;
  logic        avs_waitrequest, reqValid, reqUserLow, reqContextPtr, segCacheAttr;
  logic        rspValid, rspCacheable, rspRangeCheck, rspFillTrap, rspProtTrap, rspTrapId;
  int          failCount   = 0;
  int          comparisons = 0;

  always #5 clk_sys = ~clk_sys;

  vatu_core_model i_vatu_core_model (.clk_sys(clk_sys), .cmdGo(cmdGo), .cmdAddr(cmdAddr),
    .cmdKind(cmdKind), .cmdFlags(cmdFlags), .reqValid(reqValid), .reqAddr(reqAddr),
    .reqKind(reqKind), .reqUserLow(reqUserLow), .reqContextPtr(reqContextPtr),
    .segCacheAttr(segCacheAttr));

  vatu_translation_unit i_vatu_translation_unit (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .reqValid(reqValid), .reqAddr(reqAddr),
    .reqKind(reqKind), .reqUserLow(reqUserLow), .reqContextPtr(reqContextPtr),
    .segCacheAttr(segCacheAttr), .rspValid(rspValid), .rspAddr(rspAddr),
    .rspCacheable(rspCacheable), .rspRangeCheck(rspRangeCheck), .rspFillTrap(rspFillTrap),
    .rspProtTrap(rspProtTrap), .rspTrapId(rspTrapId));

  task automatic end_sim;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      failCount++;
      end_sim();
    end
    rdData = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rdData, e)
  endtask : rd

  // ex = {rangeCheck, cacheable, fill, prot, trapId}; f = {userLow, contextPtr, attr}
  task automatic xl(input logic [31:0] va, input logic [1:0] k, input logic [2:0] f,
                    input logic [31:0] pa, input logic [4:0] ex);
    int n;
    @(posedge clk_sys);
    cmdGo <= 1'b1;
    cmdAddr <= va;
    cmdKind <= k;
    cmdFlags <= f;
    @(posedge clk_sys);
    cmdGo <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (rspValid !== 1'b1 && n < 8);
    `CHK({rspValid, rspFillTrap, rspProtTrap, rspTrapId}, {1'b1, ex[2:0]})
    if (ex[2:1] == 2'h0) begin
      `CHK({rspRangeCheck, rspCacheable, rspAddr}, {ex[4:3], pa})
    end
  endtask : xl

  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`VATU_OFF_CONFIG, 32'h000000E0);
    rd(`VATU_OFF_ASID, 32'h00000000);
    rd(8'h40, 32'h00000000);
    $display("Test reset values finished");
    xl(32'h03456789, 2'h0, 3'h5, 32'h03456789, 5'h18);
    xl(32'h03456789, 2'h1, 3'h0, 32'h03456789, 5'h10);
    xl(32'hE0000000, 2'h0, 3'h4, 32'h0, 5'h03);
    xl(32'hF0000004, 2'h2, 3'h4, 32'h0, 5'h03);
    xl(32'hD0000000, 2'h0, 3'h4, 32'hD0000000, 5'h10);
    $display("Test physical mode finished");
    wr(`VATU_OFF_CONFIG, 32'h00008003);
    rd(`VATU_OFF_CONFIG, 32'h000000E3);
    xl(32'h03456789, 2'h0, 3'h1, 32'h0, 5'h04);
    rd(`VATU_OFF_FAULT, 32'h0000D159);
    rd(`VATU_OFF_TRAP, 32'h00000002);
    xl(32'h80000010, 2'h0, 3'h4, 32'h0, 5'h03);
    xl(32'h80000010, 2'h1, 3'h0, 32'h80000010, 5'h10);
    wr(`VATU_OFF_ASID, 32'h00000003);
    wr(`VATU_OFF_STAGE_VPN, 32'h03000012);
    wr(`VATU_OFF_STAGE_PPN, 32'h34000ABC);
    wr(`VATU_OFF_INDEX, 32'h00000000);
    wr(`VATU_OFF_COMMIT, 32'h00000000);
    xl(32'h00012345, 2'h0, 3'h5, 32'h00ABC345, 5'h08);
    xl(32'h00012345, 2'h0, 3'h0, 32'h00ABC345, 5'h00);
    xl(32'h00012345, 2'h1, 3'h1, 32'h0, 5'h03);
    xl(32'h00012345, 2'h2, 3'h1, 32'h0, 5'h03);
    xl(32'h00012345, 2'h0, 3'h3, 32'h00012345, 5'h18);
    wr(`VATU_OFF_ASID, 32'h00000004);
    xl(32'h00012345, 2'h0, 3'h1, 32'h0, 5'h04);
    wr(`VATU_OFF_STAGE_VPN, 32'h00001002);
    wr(`VATU_OFF_STAGE_PPN, 32'h8C000055);
    wr(`VATU_OFF_INDEX, 32'h00000087);
    wr(`VATU_OFF_COMMIT, 32'h00000000);
    xl(32'h00400AB0, 2'h2, 3'h1, 32'h000156B0, 5'h00);
    xl(32'h00400AB0, 2'h0, 3'h1, 32'h0, 5'h03);
    wr(`VATU_OFF_STAGE_VPN, 32'h00000048);
    wr(`VATU_OFF_STAGE_PPN, 32'h2C000001);
    wr(`VATU_OFF_INDEX, 32'h00000080);
    wr(`VATU_OFF_COMMIT, 32'h00000000);
    wr(`VATU_OFF_ASID, 32'h00000003);
    xl(32'h00012345, 2'h0, 3'h1, 32'h0, 5'h04);
    $display("Test virtual mode finished");
    end_sim();
  end
endmodule : test_virtual_address_translation_unit
